// ==== bench/dmarc_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------------------------
// memory bus responder, one answer per item on each controller
//------------------------------------------------------------------------------
module dmarc_mem_model (
   // clock and reset
   input  wire logic                                            sys_clk,
   input  wire logic                                            rstn,
   // commands from the core
   input  wire dmarc_pkg::dmarc_bus_t [dmarc_pkg::DMARC_NCTL-1:0] bus_cmd,
   // scenario controls: answer latency and error answers
   input  wire logic [3:0]                                      lat,
   input  wire logic [dmarc_pkg::DMARC_NCTL-1:0]                fail,
   // answers
   output logic [dmarc_pkg::DMARC_NCTL-1:0]                     bus_done,
   output logic [dmarc_pkg::DMARC_NCTL-1:0]                     bus_err
);
   import dmarc_pkg::*;

   logic [DMARC_NCTL-1:0][3:0] wait_q;

   // count the latency while a command stands, then one pulse and rearm
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wait_q   <= '0;
         bus_done <= '0;
         bus_err  <= '0;
      end else begin
         for (int c = 0; c < DMARC_NCTL; c++) begin
            bus_done[c] <= 1'b0;
            bus_err[c]  <= 1'b0;
            if (bus_done[c] || bus_err[c] || !bus_cmd[c].req) begin
               wait_q[c] <= 4'h0;
            end else if (wait_q[c] == lat) begin
               bus_done[c] <= !fail[c];
               bus_err[c]  <= fail[c];
            end else begin
               wait_q[c] <= wait_q[c] + 4'h1;
            end
         end
      end
   end
endmodule : dmarc_mem_model
`default_nettype wire

// ==== bench/test_dma_request_channel_core.sv ====
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------------------------
// self-checking bench of the request channel core
//------------------------------------------------------------------------------
module test_dma_request_channel_core;
   import dmarc_pkg::*;

   typedef struct packed {
      logic [3:0]   ch;
      dmarc_dir_t   dir;
      logic [3:0]   sel;
      logic [15:0]  count;
      logic         circ;
      logic [3:0]   items;
      logic [15:0]  rem;
      dmarc_flags_t flg;
   } dmarc_row_t;

   logic                                     sys_clk;
   logic                                     rstn;
   dmarc_cfg_t   [DMARC_NCH-1:0]             cfg;
   dmarc_flags_t [DMARC_NCH-1:0]             fset;
   dmarc_flags_t [DMARC_NCH-1:0]             fclr;
   logic [DMARC_NCH-1:0][DMARC_NSRC-1:0]     src_req;
   logic [DMARC_NCH-1:0]                     req_ack;
   dmarc_bus_t   [DMARC_NCTL-1:0]            bus_cmd;
   logic [DMARC_NCTL-1:0]                    bus_done;
   logic [DMARC_NCTL-1:0]                    bus_err;
   dmarc_flags_t [DMARC_NCH-1:0]             ch_flags;
   logic [DMARC_NCH-1:0]                     ch_irq;
   logic [DMARC_NCH-1:0][DMARC_CNT_W-1:0]    ch_remain;
   logic [3:0]                               lat;
   logic [DMARC_NCTL-1:0]                    fail;
   dmarc_bus_t   [DMARC_NCTL-1:0]            seen;
   logic [2:0]                               first;
   dmarc_row_t                               rows [5];
   int                                       errors;
   int                                       tests_run;

   dmarc_core uut (.sys_clk(sys_clk), .rstn(rstn), .ch_cfg(cfg), .flag_set(fset),
      .flag_clr(fclr), .src_req(src_req), .req_ack(req_ack), .bus_cmd(bus_cmd),
      .bus_done(bus_done), .bus_err(bus_err), .ch_flags(ch_flags), .ch_irq(ch_irq),
      .ch_remain(ch_remain));

   dmarc_mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .bus_cmd(bus_cmd), .lat(lat),
      .fail(fail), .bus_done(bus_done), .bus_err(bus_err));

   // clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // remember the last command of each controller
   always @(posedge sys_clk) begin
      if (bus_cmd[0].req) seen[0] <= bus_cmd[0];
      if (bus_cmd[1].req) seen[1] <= bus_cmd[1];
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
      tests_run++;
      if (seen_v !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen_v);
      end
   endtask : chk

   // a bound that ran out ends the run
   task automatic tmo(input int n);
      if (n >= 60) begin
         errors++;
         $display("BAD wait expected answer seen none");
         test_done();
      end
   endtask : tmo

   task automatic wait_ack(input int ch);
      int n;
      for (n = 0; n < 60 && req_ack[ch] !== 1'b1; n++) @(negedge sys_clk);
      tmo(n);
   endtask : wait_ack

   // one requester, one source raised, dropped on the acknowledge
   task automatic item(input int ch, input logic [3:0] sel);
      src_req[ch][sel] = 1'b1;
      wait_ack(ch);
      src_req[ch][sel] = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask : item

   function automatic dmarc_cfg_t mk(dmarc_dir_t d, logic [1:0] p, logic [3:0] s,
                                     logic [15:0] n, logic c);
      return '{en:1'b1, circ:c, dir:d, pri:p, sel:s, count:n,
               ie_half:1'b1, ie_done:1'b1, ie_err:1'b1};
   endfunction : mk

   // main sequence
   initial begin
      int n;
      int c;
      dmarc_row_t row;
      rstn = 1'b0;
      cfg = '0;
      fset = '0;
      fclr = '0;
      src_req = '0;
      lat = 4'h0;
      fail = '0;
      errors = 0;
      tests_run = 0;
      rows[0] = '{4'd0, DMARC_P2M, 4'h0, 16'h0004, 1'b1, 4'd4, 16'h0004, 3'b110};
      rows[1] = '{4'd8, DMARC_M2P, 4'h5, 16'h0003, 1'b0, 4'd3, 16'h0000, 3'b110};
      rows[2] = '{4'd6, DMARC_P2M, 4'hF, 16'h0002, 1'b1, 4'd2, 16'h0002, 3'b110};
      rows[3] = '{4'd11, DMARC_M2P, 4'h9, 16'hFFFF, 1'b0, 4'd1, 16'hFFFE, 3'b000};
      rows[4] = '{4'd3, DMARC_M2M, 4'h0, 16'h0003, 1'b0, 4'd3, 16'h0000, 3'b110};
      repeat (5) @(negedge sys_clk);
      chk("reset", {|ch_flags, |ch_irq, |ch_remain, |req_ack, |bus_cmd}, 0);
      rstn = 1'b1;
      @(negedge sys_clk);
      // table of ordinary transfers, latency grows row by row
      for (int r = 0; r < 5; r++) begin
         row = rows[r];
         c = (row.ch >= 7) ? 1 : 0;
         lat = 4'(r);
         cfg[row.ch] = mk(row.dir, 2'h0, row.sel, row.count, row.circ);
         @(negedge sys_clk);
         if (row.dir == DMARC_M2M) begin
            for (n = 0; n < 60 && ch_remain[row.ch] !== 16'h0; n++) @(negedge sys_clk);
            tmo(n);
            repeat (2) @(negedge sys_clk);
         end else begin
            for (int i = 0; i < row.items; i++) item(row.ch, row.sel);
         end
         chk("remain", ch_remain[row.ch], row.rem);
         chk("flags", ch_flags[row.ch], row.flg);
         chk("irq", ch_irq[row.ch], |row.flg);
         chk("chan", seen[c].chan, row.ch - 7 * c);
         chk("dir", seen[c].dir, row.dir);
         cfg[row.ch].en = 1'b0;
         fclr[row.ch] = 3'b111;
         @(negedge sys_clk);
         fclr = '0;
         @(negedge sys_clk);
         chk("cleared", ch_flags[row.ch], 0);
      end
      // two requests at once: level first, then lower channel
      lat = 4'h3;
      for (int p = 0; p < 2; p++) begin
         cfg[1 + 2 * p] = mk(DMARC_P2M, 2'(2 * p), 4'h0, 16'h0004, 1'b0);
         cfg[2 + 2 * p] = mk(DMARC_P2M, 2'(3 - p), 4'h0, 16'h0004, 1'b0);
         @(negedge sys_clk);
         src_req[1 + 2 * p][0] = 1'b1;
         src_req[2 + 2 * p][0] = 1'b1;
         for (n = 0; n < 60 && bus_cmd[0].req !== 1'b1; n++) @(negedge sys_clk);
         tmo(n);
         first = bus_cmd[0].chan;
         chk("winner", first, 2 + p);
         wait_ack(2 + p);
         src_req[2 + p][0] = 1'b0;
         wait_ack(1 + 3 * p);
         src_req[1 + 2 * p][0] = 1'b0;
         src_req[2 + 2 * p][0] = 1'b0;
         cfg[1 + 2 * p].en = 1'b0;
         cfg[2 + 2 * p].en = 1'b0;
      end
      // both controllers busy at once, memory to memory
      cfg[1] = mk(DMARC_M2M, 2'h0, 4'h0, 16'h0002, 1'b0);
      cfg[9] = mk(DMARC_M2M, 2'h0, 4'h0, 16'h0002, 1'b0);
      @(negedge sys_clk);
      for (n = 0; n < 60 && (ch_remain[1] | ch_remain[9]) !== 16'h0; n++) @(negedge sys_clk);
      tmo(n);
      repeat (2) @(negedge sys_clk);
      chk("both_a", {ch_flags[1], ch_remain[1]}, {3'b110, 16'h0});
      chk("both_b", {ch_flags[9], ch_remain[9]}, {3'b110, 16'h0});
      chk("both_chan", {seen[0].chan, seen[1].chan}, {3'd1, 3'd2});
      cfg[1].en = 1'b0;
      cfg[9].en = 1'b0;
      // bus error stops the channel and raises its interrupt
      fail[0] = 1'b1;
      cfg[0] = mk(DMARC_P2M, 2'h0, 4'h0, 16'h0004, 1'b0);
      repeat (2) @(negedge sys_clk);
      src_req[0][0] = 1'b1;
      for (n = 0; n < 60 && ch_flags[0].err !== 1'b1; n++) @(negedge sys_clk);
      tmo(n);
      src_req[0][0] = 1'b0;
      fail[0] = 1'b0;
      @(negedge sys_clk);
      chk("err", {ch_flags[0], ch_irq[0], ch_remain[0]}, {3'b001, 1'b1, 16'h0});
      // software set per flag, sticky, set beats clear, clear
      cfg[0] = mk(DMARC_P2M, 2'h0, 4'h0, 16'h0000, 1'b0);
      fclr[0] = 3'b111;
      @(negedge sys_clk);
      fclr = '0;
      for (int b = 0; b < 3; b++) begin
         fset[0] = 3'(1 << b);
         @(negedge sys_clk);
         fset[0] = 3'b000;
         repeat (20) @(negedge sys_clk);
         chk("swflag", {ch_flags[0], ch_irq[0]}, {3'(1 << b), 1'b1});
         fset[0] = 3'(1 << b);
         fclr[0] = 3'(1 << b);
         @(negedge sys_clk);
         fset[0] = 3'b000;
         fclr[0] = 3'b000;
         @(negedge sys_clk);
         chk("setwins", ch_flags[0], 1 << b);
         fclr[0] = 3'(1 << b);
         @(negedge sys_clk);
         fclr[0] = 3'b000;
         @(negedge sys_clk);
         chk("swclr", {ch_flags[0], ch_irq[0]}, 0);
      end
      // masked flag stays silent
      cfg[0].ie_done = 1'b0;
      fset[0] = 3'b010;
      @(negedge sys_clk);
      fset[0] = 3'b000;
      @(negedge sys_clk);
      chk("masked", {ch_flags[0], ch_irq[0]}, {3'b010, 1'b0});
      // second reset in mid-run clears the flags
      rstn = 1'b0;
      @(negedge sys_clk);
      chk("rereset", {|ch_flags, |ch_irq, |ch_remain}, 0);
      rstn = 1'b1;
      repeat (2) @(negedge sys_clk);
      test_done();
   end
endmodule : test_dma_request_channel_core
`default_nettype wire

// ==== rtl/dmarc_arb.sv ====
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------------------------
// channel arbiter: highest software level, then lowest channel number
//------------------------------------------------------------------------------
module dmarc_arb #(
   parameter int N  = 7,
   parameter int PW = 2,
   parameter int IW = 3
) (
   // pending requests and their levels
   input  wire logic [N-1:0]         req,
   input  wire logic [N-1:0][PW-1:0] pri,
   // grant
   output logic                      gnt_vld,
   output logic [IW-1:0]             gnt_idx
);

   logic [PW-1:0] best_pri;

   // strict greater keeps the lower index on a tie
   always_comb begin
      gnt_vld  = 1'b0;
      gnt_idx  = '0;
      best_pri = '0;
      for (int i = 0; i < N; i++) begin
         if (req[i] && (!gnt_vld || pri[i] > best_pri)) begin
            gnt_vld  = 1'b1;
            gnt_idx  = IW'(i);
            best_pri = pri[i];
         end
      end
   end

endmodule : dmarc_arb
`default_nettype wire

// ==== rtl/dmarc_core.sv ====
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
module dmarc_core (
   // clock and reset
   input  wire logic                                            sys_clk,
   input  wire logic                                            rstn,
   // channel configuration and software flag access
   input  wire dmarc_pkg::dmarc_cfg_t   [dmarc_pkg::DMARC_NCH-1:0] ch_cfg,
   input  wire dmarc_pkg::dmarc_flags_t [dmarc_pkg::DMARC_NCH-1:0] flag_set,
   input  wire dmarc_pkg::dmarc_flags_t [dmarc_pkg::DMARC_NCH-1:0] flag_clr,
   // request sources and acknowledges
   input  wire logic [dmarc_pkg::DMARC_NCH-1:0][dmarc_pkg::DMARC_NSRC-1:0] src_req,
   output logic [dmarc_pkg::DMARC_NCH-1:0]                      req_ack,
   // memory bus, one command port per controller
   output var dmarc_pkg::dmarc_bus_t [dmarc_pkg::DMARC_NCTL-1:0] bus_cmd,
   input  wire logic [dmarc_pkg::DMARC_NCTL-1:0]                bus_done,
   input  wire logic [dmarc_pkg::DMARC_NCTL-1:0]                bus_err,
   // channel status
   output var dmarc_pkg::dmarc_flags_t [dmarc_pkg::DMARC_NCH-1:0] ch_flags,
   output logic [dmarc_pkg::DMARC_NCH-1:0]                      ch_irq,
   output logic [dmarc_pkg::DMARC_NCH-1:0][dmarc_pkg::DMARC_CNT_W-1:0] ch_remain
);
   import dmarc_pkg::*;

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic         [DMARC_NCH-1:0][DMARC_NSRC-1:0]   sync1;
      logic         [DMARC_NCH-1:0][DMARC_NSRC-1:0]   sync2;
      logic         [DMARC_NCH-1:0][DMARC_CNT_W-1:0]  rem;
      logic         [DMARC_NCH-1:0]                   armed;
      logic         [DMARC_NCH-1:0][DMARC_HOLD_W-1:0] hold;
      dmarc_flags_t [DMARC_NCH-1:0]                   flg;
      logic         [DMARC_NCH-1:0]                   ack;
      logic         [DMARC_NCH-1:0]                   irq;
      dmarc_st_t    [DMARC_NCTL-1:0]                  st;
      dmarc_bus_t   [DMARC_NCTL-1:0]                  bus;
   } dmarc_core_st_t;

   dmarc_core_st_t                              q;
   dmarc_core_st_t                              d;
   logic         [DMARC_NCH-1:0]                ch_req;
   logic         [DMARC_NCH-1:0][DMARC_PRI_W-1:0] pri_all;
   logic         [DMARC_NCTL-1:0]               arb_vld;
   logic         [DMARC_NCTL-1:0][DMARC_IDX_W-1:0] arb_idx;

   //---------------------------------------------------------------------------
   // channel request qualification
   //---------------------------------------------------------------------------
   // a channel asks only when armed, not drained and past its holdoff
   always_comb begin
      for (int i = 0; i < DMARC_NCH; i++) begin
         pri_all[i] = ch_cfg[i].pri;
         ch_req[i]  = ch_cfg[i].en && q.armed[i] && (q.rem[i] != '0)
                      && (q.hold[i] == '0)
                      && ((ch_cfg[i].dir == DMARC_M2M)
                          || q.sync2[i][ch_cfg[i].sel]);
      end
   end

   //---------------------------------------------------------------------------
   // one arbiter per controller
   //---------------------------------------------------------------------------
   for (genvar c = 0; c < DMARC_NCTL; c++) begin : g_ctl
      localparam int BASE = (c == 0) ? 0 : DMARC_NCH_A;
      localparam int NC   = (c == 0) ? DMARC_NCH_A : DMARC_NCH_B;
      dmarc_arb #(
         .N  (NC),
         .PW (DMARC_PRI_W),
         .IW (DMARC_IDX_W)
      ) u_arb (
         .req     (ch_req[BASE +: NC]),
         .pri     (pri_all[BASE +: NC]),
         .gnt_vld (arb_vld[c]),
         .gnt_idx (arb_idx[c])
      );
   end

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   always_comb begin
      int           base;
      int           ctl;
      logic [DMARC_CNT_W-1:0] nrem;
      logic         served;
      dmarc_flags_t hw;
      base   = 0;
      ctl    = 0;
      nrem   = '0;
      served = 1'b0;
      hw     = '0;
      d       = q;
      d.sync1 = src_req;
      d.sync2 = q.sync1;
      d.ack   = '0;

      // controller sequencing: one item in flight per controller
      for (int c = 0; c < DMARC_NCTL; c++) begin
         base = (c == 0) ? 0 : DMARC_NCH_A;
         case (q.st[c])
            DMARC_IDLE: begin
               if (arb_vld[c]) begin
                  d.st[c]       = DMARC_BUSY;
                  d.bus[c].chan = arb_idx[c];
                  d.bus[c].dir  = ch_cfg[base + int'(arb_idx[c])].dir;
               end
            end
            DMARC_BUSY: begin
               if (bus_done[c] || bus_err[c]) begin
                  d.st[c] = DMARC_IDLE;
               end
            end
            default: d.st[c] = DMARC_IDLE;
         endcase
         d.bus[c].req = (d.st[c] == DMARC_BUSY);
      end

      // per-channel counting, flags and interrupt
      for (int i = 0; i < DMARC_NCH; i++) begin
         ctl    = (i < DMARC_NCH_A) ? 0 : 1;
         base   = (ctl == 0) ? 0 : DMARC_NCH_A;
         hw     = '0;
         nrem   = q.rem[i] - 16'h1;
         served = (q.st[ctl] == DMARC_BUSY)
                  && (q.bus[ctl].chan == DMARC_IDX_W'(i - base));
         if (q.hold[i] != '0) begin
            d.hold[i] = q.hold[i] - 2'h1;
         end
         if (served && bus_err[ctl]) begin
            hw.err   = 1'b1;
            d.rem[i] = '0;                                               // stop the channel
         end else if (served && bus_done[ctl]) begin
            if (q.bus[ctl].dir != DMARC_M2M) begin
               d.ack[i]  = 1'b1;
               d.hold[i] = DMARC_HOLD_CYC;
            end
            if ((nrem == (ch_cfg[i].count >> 1)) && (nrem != '0)) begin
               hw.half = 1'b1;
            end
            if (nrem == '0) begin
               hw.done  = 1'b1;
               d.rem[i] = ch_cfg[i].circ ? ch_cfg[i].count : '0;
            end else begin
               d.rem[i] = nrem;
            end
         end
         // arming loads the programmed count, disabling drops it
         if (!ch_cfg[i].en) begin
            d.armed[i] = 1'b0;
            d.rem[i]   = '0;
         end else if (!q.armed[i]) begin
            d.armed[i] = 1'b1;
            d.rem[i]   = ch_cfg[i].count;
         end
         // set wins over clear, software set behaves as a hardware event
         d.flg[i] = dmarc_flags_t'((q.flg[i] & ~flag_clr[i]) | hw | flag_set[i]);
         d.irq[i] = |(d.flg[i] & {ch_cfg[i].ie_half, ch_cfg[i].ie_done,
                                  ch_cfg[i].ie_err});
      end
   end

   //---------------------------------------------------------------------------
   // state register
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign req_ack   = q.ack;
   assign bus_cmd   = q.bus;
   assign ch_flags  = q.flg;
   assign ch_irq    = q.irq;
   assign ch_remain = q.rem;

   //---------------------------------------------------------------------------
   // checks
   //---------------------------------------------------------------------------
   default clocking dmarc_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   logic beaten0;
   logic done_ev0;
   logic err_ev0;

   // helper: a better request exists than the one granted on controller a
   always_comb begin
      beaten0 = 1'b0;
      for (int j = 0; j < DMARC_NCH_A; j++) begin
         if (ch_req[j] && ((pri_all[j] > pri_all[int'(arb_idx[0])])
             || ((pri_all[j] == pri_all[int'(arb_idx[0])]) && (j < int'(arb_idx[0]))))) begin
            beaten0 = 1'b1;
         end
      end
   end

   // helper: last item of channel 0 finishes cleanly
   assign done_ev0 = (q.st[0] == DMARC_BUSY) && (q.bus[0].chan == '0) && bus_done[0]
                     && !bus_err[0] && (q.rem[0] == 16'h1) && ch_cfg[0].en;

   // helper: an item of channel 0 ends in a bus error
   assign err_ev0 = (q.st[0] == DMARC_BUSY) && (q.bus[0].chan == '0) && bus_err[0];

   property p_bus_hold;
      (bus_cmd[0].req && !bus_done[0] && !bus_err[0])
         |=> bus_cmd[0].req && $stable(bus_cmd[0].chan);
   endproperty
   a_bus_hold: assert property (p_bus_hold)
      else $error("controller dropped or changed a request in flight");

   property p_grant_is_req;
      arb_vld[0] |-> ch_req[int'(arb_idx[0])];
   endproperty
   a_grant_is_req: assert property (p_grant_is_req)
      else $error("grant given to a channel that is not requesting");

   property p_arb_order;
      arb_vld[0] |-> !beaten0;
   endproperty
   a_arb_order: assert property (p_arb_order)
      else $error("grant ignored level or fixed channel order");

   property p_done_flag;
      done_ev0 |=> ch_flags[0].done ##1 (ch_flags[0].done || $past(flag_clr[0].done));
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("complete flag not raised on last item");

   property p_sw_set;
      (flag_set[0].err && ch_cfg[0].ie_err) |=> ch_flags[0].err && ch_irq[0];
   endproperty
   a_sw_set: assert property (p_sw_set)
      else $error("software set did not raise flag and interrupt");

   property p_circ;
      (done_ev0 && ch_cfg[0].circ) |=> (ch_remain[0] == $past(ch_cfg[0].count));
   endproperty
   a_circ: assert property (p_circ)
      else $error("circular mode did not reload the count");

   property p_ack_hold;
      req_ack[0] |=> (!req_ack[0] && !ch_req[0]) [*3];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("acknowledge not a pulse or holdoff too short");

   property p_sticky;
      (ch_flags[0].done && !flag_clr[0].done) |=> ch_flags[0].done;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag lost without a clear");

   property p_irq_src;
      ch_irq[0] |-> (ch_flags[0] != '0);
   endproperty
   a_irq_src: assert property (p_irq_src)
      else $error("interrupt without any flag set");

   property p_err_stop;
      err_ev0 |=> ch_flags[0].err && (ch_remain[0] == '0);
   endproperty
   a_err_stop: assert property (p_err_stop)
      else $error("bus error did not flag and stop the channel");

   property p_cov_sw;
      flag_set[0].err && flag_clr[0].err;
   endproperty
   c_cov_sw: cover property (p_cov_sw);

   property p_cov_circ;
      done_ev0 && ch_cfg[0].circ;
   endproperty
   c_cov_circ: cover property (p_cov_circ);

   property p_cov_err;
      bus_cmd[0].req && bus_err[0];
   endproperty
   c_cov_err: cover property (p_cov_err);

   property p_cov_both;
      bus_cmd[0].req && bus_cmd[1].req;
   endproperty
   c_cov_both: cover property (p_cov_both);

endmodule : dmarc_core
`default_nettype wire

// ==== rtl/dmarc_pkg.sv ====
//------------------------------------------------------------------------------
// shared constants and types of the request channel core
//------------------------------------------------------------------------------
package dmarc_pkg;

   // controller and channel counts
   localparam int DMARC_NCH_A  = 7;   // channels of the seven_channel_controller
   localparam int DMARC_NCH_B  = 5;   // channels of the five_channel_controller
   localparam int DMARC_NCH    = 12;  // all channels, controller a first
   localparam int DMARC_NCTL   = 2;
   localparam int DMARC_IDX_W  = 3;   // local channel index width
   // transfer counter
   localparam int              DMARC_CNT_W   = 16;
   localparam logic [15:0]     DMARC_CNT_MAX = 16'hFFFF;
   // request selection
   localparam int              DMARC_SEL_W   = 4;
   localparam int              DMARC_NSRC    = 16;
   localparam logic [3:0]      DMARC_SEL_FIX = 4'h0;   // fixed per-channel source group
   // priority level width, software levels 0 (low) to 3 (very high)
   localparam int              DMARC_PRI_W   = 2;
   // request holdoff after an acknowledge, covers the input synchroniser
   localparam int              DMARC_HOLD_W  = 2;
   localparam logic [1:0]      DMARC_HOLD_CYC = 2'h3;

   // transfer direction
   typedef enum logic [1:0] {
      DMARC_P2M,
      DMARC_M2P,
      DMARC_M2M
   } dmarc_dir_t;

   // controller state
   typedef enum logic {
      DMARC_IDLE,
      DMARC_BUSY
   } dmarc_st_t;

   // per-channel configuration
   typedef struct packed {
      logic                    en;
      logic                    circ;
      dmarc_dir_t              dir;
      logic [DMARC_PRI_W-1:0]  pri;
      logic [DMARC_SEL_W-1:0]  sel;   // request_select_code
      logic [DMARC_CNT_W-1:0]  count;
      logic                    ie_half;
      logic                    ie_done;
      logic                    ie_err;
   } dmarc_cfg_t;

   // per-channel event flags, same order as the enables above
   typedef struct packed {
      logic half;
      logic done;
      logic err;
   } dmarc_flags_t;

   // memory bus command of one controller
   typedef struct packed {
      logic                    req;
      logic [DMARC_IDX_W-1:0]  chan;
      dmarc_dir_t              dir;
   } dmarc_bus_t;

endpackage : dmarc_pkg
